/* pkg/rivp_pkg.sv */
// Purpose: shared constants and types for reset and interrupt vector placement
// Assumes: one program word per vector slot, 12-bit program word address
// Notes: slot values are offsets from the vector section base

package rivp_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SRC_N = 25;
  localparam int unsigned SRC_W = 5;
  localparam int unsigned CAUSE_N = 4;

  // section bases
  localparam logic [ADDR_W-1:0] APP_SECTION_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] BOOT_RESET_ADDR = 12'hc00;
  localparam logic [ADDR_W-1:0] RESET_SLOT = 12'h000;

  // fuse encoding: zero means programmed
  localparam logic FUSE_PROGRAMMED = 1'b0;
  localparam logic FUSE_UNPROGRAMMED = 1'b1;
  localparam logic VEC_SEL_BOOT = 1'b1;

  // source indices, in table order
  localparam logic [SRC_W-1:0] SRC_EXT_IRQ_ZERO = 5'h00;
  localparam logic [SRC_W-1:0] SRC_SELF_PROGRAM_READY = 5'h18;

  // vector slots, one word each
  localparam logic [ADDR_W-1:0] SLOT_EXT_IRQ_ZERO = 12'h001;
  localparam logic [ADDR_W-1:0] SLOT_EXT_IRQ_ONE = 12'h002;
  localparam logic [ADDR_W-1:0] SLOT_PIN_CHANGE_IRQ_ZERO = 12'h003;
  localparam logic [ADDR_W-1:0] SLOT_PIN_CHANGE_IRQ_ONE = 12'h004;
  localparam logic [ADDR_W-1:0] SLOT_PIN_CHANGE_IRQ_TWO = 12'h005;
  localparam logic [ADDR_W-1:0] SLOT_WATCHDOG_TIMEOUT_IRQ = 12'h006;
  localparam logic [ADDR_W-1:0] SLOT_TMR_B_MATCH_A_IRQ = 12'h007;
  localparam logic [ADDR_W-1:0] SLOT_TMR_B_MATCH_B_IRQ = 12'h008;
  localparam logic [ADDR_W-1:0] SLOT_TMR_B_OVERFLOW_IRQ = 12'h009;
  localparam logic [ADDR_W-1:0] SLOT_WIDE_TMR_CAPTURE_IRQ = 12'h00a;
  localparam logic [ADDR_W-1:0] SLOT_WIDE_TMR_MATCH_A_IRQ = 12'h00b;
  localparam logic [ADDR_W-1:0] SLOT_WIDE_TMR_MATCH_B_IRQ = 12'h00c;
  localparam logic [ADDR_W-1:0] SLOT_WIDE_TMR_OVERFLOW_IRQ = 12'h00d;
  localparam logic [ADDR_W-1:0] SLOT_TMR_A_MATCH_A_IRQ = 12'h00e;
  localparam logic [ADDR_W-1:0] SLOT_TMR_A_MATCH_B_IRQ = 12'h00f;
  localparam logic [ADDR_W-1:0] SLOT_TMR_A_OVERFLOW_IRQ = 12'h010;
  localparam logic [ADDR_W-1:0] SLOT_SPI_XFER_DONE_IRQ = 12'h011;
  localparam logic [ADDR_W-1:0] SLOT_USART_RX_DONE_IRQ = 12'h012;
  localparam logic [ADDR_W-1:0] SLOT_USART_TX_EMPTY_IRQ = 12'h013;
  localparam logic [ADDR_W-1:0] SLOT_USART_TX_DONE_IRQ = 12'h014;
  localparam logic [ADDR_W-1:0] SLOT_ADC_DONE_IRQ = 12'h015;
  localparam logic [ADDR_W-1:0] SLOT_EEPROM_READY_IRQ = 12'h016;
  localparam logic [ADDR_W-1:0] SLOT_ANALOG_CMP_IRQ = 12'h017;
  localparam logic [ADDR_W-1:0] SLOT_TWO_WIRE_IRQ = 12'h018;
  localparam logic [ADDR_W-1:0] SLOT_SELF_PROGRAM_READY_IRQ = 12'h019;

  // reset cause bit positions
  localparam int unsigned CAUSE_PIN = 0;
  localparam int unsigned CAUSE_POWER_ON = 1;
  localparam int unsigned CAUSE_BROWN_OUT = 2;
  localparam int unsigned CAUSE_WATCHDOG = 3;
  localparam logic [CAUSE_N-1:0] CAUSE_NONE = 4'h0;
  localparam logic [CAUSE_N-1:0] CAUSE_POWER_ON_ONLY = 4'h2;

  typedef enum logic [1:0] {
    RIVP_ST_STRAP,
    RIVP_ST_RESET_FETCH,
    RIVP_ST_IDLE
  } rivp_state_e_t;

endpackage

/* pkg/rivp_vec_if.sv */
// Purpose: carries source, slot and address terms between the vector modules
// Assumes: all signals combinational within the core clock domain
// Notes: the top drives the control side and keeps plain ports itself

`timescale 1ns/100ps

interface rivp_vec_if;
  import rivp_pkg::*;

  logic [SRC_W-1:0] source;
  logic source_ok;
  logic [ADDR_W-1:0] slot;
  logic boot_fuse;
  logic vec_select;
  logic [ADDR_W-1:0] reset_addr;
  logic [ADDR_W-1:0] vec_addr;

  modport map (input source, output source_ok, output slot);
  modport gen (input boot_fuse, input vec_select, input slot,
    output reset_addr, output vec_addr);
  modport ctrl (output source, output boot_fuse, output vec_select,
    input source_ok, input slot, input reset_addr, input vec_addr);
endinterface // rivp_vec_if

/* hw/rivp_slot_map.sv */
// Purpose: maps an interrupt source index to its vector slot
// Assumes: source index follows table order, zero for the first external request
// Notes: out-of-range indices give the reset slot and clear source_ok

`timescale 1ns/100ps

module rivp_slot_map (
  // slot lookup
  rivp_vec_if.map vec
);
  import rivp_pkg::*;

  function automatic logic [ADDR_W-1:0] slot_of(input logic [SRC_W-1:0] src);
    logic [ADDR_W-1:0] s;
    s = RESET_SLOT;
    case (src)
      5'h00: s = SLOT_EXT_IRQ_ZERO; // [R2]
      5'h01: s = SLOT_EXT_IRQ_ONE; // [R2]
      5'h02: s = SLOT_PIN_CHANGE_IRQ_ZERO; // [R3]
      5'h03: s = SLOT_PIN_CHANGE_IRQ_ONE; // [R3]
      5'h04: s = SLOT_PIN_CHANGE_IRQ_TWO; // [R3]
      5'h05: s = SLOT_WATCHDOG_TIMEOUT_IRQ; // [R3]
      5'h06: s = SLOT_TMR_B_MATCH_A_IRQ; // [R4]
      5'h07: s = SLOT_TMR_B_MATCH_B_IRQ; // [R4]
      5'h08: s = SLOT_TMR_B_OVERFLOW_IRQ; // [R4]
      5'h09: s = SLOT_WIDE_TMR_CAPTURE_IRQ; // [R5]
      5'h0a: s = SLOT_WIDE_TMR_MATCH_A_IRQ; // [R5]
      5'h0b: s = SLOT_WIDE_TMR_MATCH_B_IRQ; // [R5]
      5'h0c: s = SLOT_WIDE_TMR_OVERFLOW_IRQ; // [R5]
      5'h0d: s = SLOT_TMR_A_MATCH_A_IRQ; // [R6]
      5'h0e: s = SLOT_TMR_A_MATCH_B_IRQ; // [R6]
      5'h0f: s = SLOT_TMR_A_OVERFLOW_IRQ; // [R6]
      5'h10: s = SLOT_SPI_XFER_DONE_IRQ; // [R7]
      5'h11: s = SLOT_USART_RX_DONE_IRQ; // [R8]
      5'h12: s = SLOT_USART_TX_EMPTY_IRQ; // [R8]
      5'h13: s = SLOT_USART_TX_DONE_IRQ; // [R8]
      5'h14: s = SLOT_ADC_DONE_IRQ; // [R9]
      5'h15: s = SLOT_EEPROM_READY_IRQ; // [R9]
      5'h16: s = SLOT_ANALOG_CMP_IRQ; // [R9]
      5'h17: s = SLOT_TWO_WIRE_IRQ; // [R9]
      5'h18: s = SLOT_SELF_PROGRAM_READY_IRQ; // [R9]
      default: s = RESET_SLOT;
    endcase
    return s;
  endfunction

  assign vec.slot = slot_of(vec.source);
  assign vec.source_ok = (vec.source <= SRC_SELF_PROGRAM_READY);
endmodule // rivp_slot_map

/* hw/rivp_addr_gen.sv */
// Purpose: forms the reset address and the vector fetch address
// Assumes: boot fuse value already captured at reset by the caller
// Notes: purely combinational; the caller registers the result

`timescale 1ns/100ps

module rivp_addr_gen (
  // address terms
  rivp_vec_if.gen vec
);
  import rivp_pkg::*;

  logic [ADDR_W-1:0] vec_base;

  // reset address follows the fuse only
  assign vec.reset_addr = (vec.boot_fuse == FUSE_PROGRAMMED) ?
    BOOT_RESET_ADDR : (APP_SECTION_BASE + RESET_SLOT); // [R1] [R10] [R12] [R13]

  // vector base follows the select bit only
  assign vec_base = (vec.vec_select == VEC_SEL_BOOT) ?
    BOOT_RESET_ADDR : APP_SECTION_BASE; // [R11] [R12]

  // one word per slot, so base plus slot needs no scaling
  assign vec.vec_addr = vec_base + vec.slot; // [R11] [R15]
endmodule // rivp_addr_gen

/* hw/rivp_top.sv */
// Purpose: reset and interrupt vector address generator for the core
// Assumes: core picks the winning source; inputs synchronous to i_clk_sys
// Notes: fetch address and flags are registered, take_ready and o_irq_pending are combinational
//
// How it works
// R1: any reset kind fetches from word zero unless boot reset is selected.
// R2: external request zero uses slot one, request one slot two.
// R3: pin change requests use slots three to five, watchdog slot six.
// R4: second 8-bit timer uses slots seven, eight and nine.
// R5: 16-bit timer uses slots ten to thirteen.
// R6: first 8-bit timer uses slots fourteen to sixteen.
// R7: serial peripheral transfer done uses slot seventeen.
// R8: usart receive, data empty and transmit done use slots eighteen to twenty.
// R9: converter, eeprom, comparator, two-wire, self-program use slots 21 to 25.
// R10: programmed boot fuse starts execution at the boot reset address.
// R11: vector select set puts vectors at boot section start plus slot.
// R12: reset address from fuse alone, vector base from select bit alone.
// R13: fuse one means unprogrammed, zero means programmed.
// R14: software may use vector slots for code when vectors are unused.
// R15: vector address is base plus slot, one word per slot.

`timescale 1ns/100ps

module rivp_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // reset sources, one bit each: pin, power-on, brown-out, watchdog
  input wire logic [rivp_pkg::CAUSE_N-1:0] i_reset_src,
  // configuration
  input wire logic i_boot_reset_fuse,
  input wire logic i_vector_base_select,
  // peripheral interrupt requests, bit n is source index n
  input wire logic [rivp_pkg::SRC_N-1:0] i_irq_req,
  // core interrupt take
  input wire logic i_irq_take,
  input wire logic [rivp_pkg::SRC_W-1:0] i_irq_source,
  output logic o_take_ready,
  output logic o_irq_pending,
  // fetch address to the core
  output logic [rivp_pkg::ADDR_W-1:0] o_fetch_addr,
  output logic o_fetch_valid,
  output logic o_fetch_is_reset,
  // status
  output logic [rivp_pkg::CAUSE_N-1:0] o_reset_cause,
  output logic o_boot_reset_active,
  output logic o_vectors_in_boot,
  output logic o_sections_split,
  output logic o_spurious_take,
  output logic o_bad_source
);
  import rivp_pkg::*;

  typedef struct packed {
    rivp_state_e_t state;
    logic fuse;
    logic vec_in_boot;
    logic [ADDR_W-1:0] fetch_addr;
    logic fetch_valid;
    logic fetch_is_reset;
    logic [CAUSE_N-1:0] cause;
    logic [CAUSE_N-1:0] pend_cause;
    logic spurious;
    logic bad_source;
  } rivp_regs_t;

  rivp_regs_t r;
  rivp_regs_t next_r;

  rivp_vec_if vec ();

  logic any_reset;
  logic take_ok;
  logic [SRC_N-1:0] req_seen;

  // slot lookup and address forming
  rivp_slot_map u_slot_map (
    .vec(vec.map)
  );

  rivp_addr_gen u_addr_gen (
    .vec(vec.gen)
  );

  assign vec.source = i_irq_source;
  assign vec.boot_fuse = r.fuse; // [R13]
  assign vec.vec_select = i_vector_base_select; // [R12]

  // per-source request qualification
  genvar g;
  generate
    for (g = 0; g < SRC_N; g++) begin : g_req
      assign req_seen[g] = i_irq_req[g] &&
        (i_irq_source == SRC_W'(g));
    end
  endgenerate

  assign any_reset = |i_reset_src;
  // a reset request in the same cycle always beats a take
  assign take_ok = (r.state == RIVP_ST_IDLE) && !any_reset;

  always_comb begin
    next_r = r;
    next_r.fetch_valid = 1'b0;
    next_r.fetch_is_reset = 1'b0;
    next_r.spurious = 1'b0;
    next_r.bad_source = 1'b0;
    case (r.state)
      RIVP_ST_STRAP: begin
        // fuse is a strap: caught here, after reset release
        next_r.fuse = i_boot_reset_fuse; // [R13]
        next_r.cause = r.pend_cause;
        next_r.pend_cause = CAUSE_NONE;
        next_r.state = RIVP_ST_RESET_FETCH;
      end
      RIVP_ST_RESET_FETCH: begin
        if (any_reset) begin
          next_r.pend_cause = i_reset_src;
          next_r.state = RIVP_ST_STRAP;
        end else begin
          next_r.fetch_addr = vec.reset_addr; // [R1] [R10] [R12]
          next_r.fetch_valid = 1'b1;
          next_r.fetch_is_reset = 1'b1;
          next_r.state = RIVP_ST_IDLE;
        end
      end
      RIVP_ST_IDLE: begin
        next_r.vec_in_boot = (i_vector_base_select == VEC_SEL_BOOT);
        if (any_reset) begin
          // every reset kind restarts through strap and a new fetch from the reset address
          next_r.pend_cause = i_reset_src; // [R1]
          next_r.state = RIVP_ST_STRAP;
        end else if (i_irq_take) begin
          if (vec.source_ok) begin
            next_r.fetch_addr = vec.vec_addr; // [R11] [R15]
            next_r.fetch_valid = 1'b1;
            next_r.spurious = ~|req_seen;
          end else begin
            // no slot exists: refuse without a fetch
            next_r.bad_source = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = RIVP_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      r.state <= RIVP_ST_STRAP;
      r.fuse <= FUSE_UNPROGRAMMED;
      r.vec_in_boot <= 1'b0;
      r.fetch_addr <= APP_SECTION_BASE;
      r.fetch_valid <= 1'b0;
      r.fetch_is_reset <= 1'b0;
      r.cause <= CAUSE_NONE;
      // the async reset itself counts as power-on
      r.pend_cause <= CAUSE_POWER_ON_ONLY;
      r.spurious <= 1'b0;
      r.bad_source <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign o_take_ready = take_ok;
  assign o_irq_pending = |i_irq_req;
  assign o_fetch_addr = r.fetch_addr;
  assign o_fetch_valid = r.fetch_valid;
  assign o_fetch_is_reset = r.fetch_is_reset;
  assign o_reset_cause = r.cause;
  assign o_boot_reset_active = (r.fuse == FUSE_PROGRAMMED); // [R13]
  assign o_vectors_in_boot = r.vec_in_boot;
  // reset and vectors in different sections leave the slots free for code
  assign o_sections_split = o_boot_reset_active ^ r.vec_in_boot; // [R14]
  assign o_spurious_take = r.spurious;
  assign o_bad_source = r.bad_source;
endmodule // rivp_top

/* sim/rivp_chk.sv */
// Purpose: port checks on the vector address generator
// Assumes: one clock domain, async active-high reset
// Notes: take checks skip cycles that also carry a reset request
`timescale 1ns/100ps
module rivp_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // stimulus
  input wire logic [rivp_pkg::CAUSE_N-1:0] i_reset_src,
  input wire logic i_boot_reset_fuse,
  input wire logic i_vector_base_select,
  input wire logic [rivp_pkg::SRC_N-1:0] i_irq_req,
  input wire logic i_irq_take,
  input wire logic [rivp_pkg::SRC_W-1:0] i_irq_source,
  // responses
  input wire logic o_take_ready,
  input wire logic [rivp_pkg::ADDR_W-1:0] o_fetch_addr,
  input wire logic o_fetch_valid,
  input wire logic o_fetch_is_reset,
  input wire logic [rivp_pkg::CAUSE_N-1:0] o_reset_cause,
  input wire logic o_boot_reset_active,
  input wire logic o_vectors_in_boot,
  input wire logic o_sections_split,
  input wire logic o_spurious_take,
  input wire logic o_bad_source
);
  import rivp_pkg::*;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  logic tk;
  assign tk = i_irq_take && o_take_ready && i_reset_src == CAUSE_NONE;
  AST_TAKE_ADDR: assert property (
    tk && i_irq_source < 5'h19 |=> o_fetch_valid && !o_fetch_is_reset && o_fetch_addr ==
    ($past(i_vector_base_select) ? BOOT_RESET_ADDR : 12'h000) + 12'($past(i_irq_source)) + 12'h001)
    else $error("vector address wrong");
  AST_BAD_SRC: assert property (
    tk && i_irq_source > 5'h18 |=> o_bad_source && !o_fetch_valid)
    else $error("out of range source fetched");
  AST_SPURIOUS: assert property (
    tk && i_irq_source < 5'h19 |=> o_spurious_take == !$past(i_irq_req[i_irq_source]))
    else $error("spurious flag wrong");
  AST_RST_ADDR: assert property (
    o_fetch_valid && o_fetch_is_reset |-> o_fetch_addr ==
    (o_boot_reset_active ? BOOT_RESET_ADDR : RESET_SLOT))
    else $error("reset address wrong");
  AST_FUSE: assert property (
    o_fetch_valid && o_fetch_is_reset |-> o_boot_reset_active == !$past(i_boot_reset_fuse, 2))
    else $error("fuse decoded wrongly");
  AST_RST_SEQ: assert property (
    (i_reset_src != CAUSE_NONE && $past(o_take_ready)) ##1
    (i_reset_src == CAUSE_NONE) [*2] |=>
    o_fetch_valid && o_fetch_is_reset && o_reset_cause == $past(i_reset_src, 3))
    else $error("reset fetch late or cause wrong");
  AST_NO_TAKE: assert property (
    i_reset_src != CAUSE_NONE |=> !o_take_ready [*2])
    else $error("take allowed during reset fetch");
  AST_VEC_SEL: assert property (
    o_take_ready |=> o_vectors_in_boot == $past(i_vector_base_select))
    else $error("vector select not tracked");
  AST_SPLIT: assert property (
    o_sections_split == (o_boot_reset_active ^ o_vectors_in_boot))
    else $error("split flag wrong");
endmodule // rivp_chk

/* sim/rivp_core_model.sv */
// Purpose: core side model presenting interrupt takes
// Assumes: takes change just after the falling edge
// Notes: index is scrambled while no take is shown
`timescale 1ns/100ps
module rivp_core_model (
  // clock
  input wire logic i_clk_sys,
  // take to the generator
  output logic o_irq_take,
  output logic [rivp_pkg::SRC_W-1:0] o_irq_source
);
  import rivp_pkg::*;
  initial begin
    o_irq_take = 1'b0;
    o_irq_source = 5'h00;
  end
  // n back to back takes, index counting up from s
  task automatic take(input logic [SRC_W-1:0] s, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge i_clk_sys);
      o_irq_take = 1'b1;
      o_irq_source = s + 5'(i);
    end
    @(negedge i_clk_sys);
    o_irq_take = 1'b0;
    o_irq_source = ~o_irq_source;
  endtask
endmodule // rivp_core_model

/* sim/reset_irq_vector_placement_bench.sv */
// Purpose: self-checking bench for the vector address generator
// Assumes: core model issues takes, bench drives the rest
// Notes: takes are checked one at a time; bursts rely on the checker
`timescale 1ns/100ps
module reset_irq_vector_placement_bench;
  import rivp_pkg::*;
  logic clk, rst, fuse, vsel, take, ready, pend, fval, fisr, boot, vinb, split, spur, bad;
  logic [CAUSE_N-1:0] rsrc, cause;
  logic [SRC_N-1:0] req;
  logic [SRC_W-1:0] src, rs;
  logic [ADDR_W-1:0] faddr;
  int n_errors = 0;
  int compares = 0;
  int seed = 99;
  rivp_top i_dut (.i_clk_sys(clk), .i_rst(rst), .i_reset_src(rsrc), .i_boot_reset_fuse(fuse),
    .i_vector_base_select(vsel), .i_irq_req(req), .i_irq_take(take), .i_irq_source(src),
    .o_take_ready(ready), .o_irq_pending(pend), .o_fetch_addr(faddr), .o_fetch_valid(fval),
    .o_fetch_is_reset(fisr), .o_reset_cause(cause), .o_boot_reset_active(boot),
    .o_vectors_in_boot(vinb), .o_sections_split(split), .o_spurious_take(spur),
    .o_bad_source(bad));
  rivp_core_model i_core (.i_clk_sys(clk), .o_irq_take(take), .o_irq_source(src));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk_val(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_addr(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
    chk_val(nm, e, g);
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    chk_val(nm, {11'h000, e}, {11'h000, g});
  endtask
  task automatic chk_cause(input string nm, input logic [CAUSE_N-1:0] e, input logic [CAUSE_N-1:0] g);
    chk_val(nm, {8'h00, e}, {8'h00, g});
  endtask
  function automatic logic [ADDR_W-1:0] exp_vec(input logic sel, input logic [SRC_W-1:0] s);
    return (sel ? BOOT_RESET_ADDR : 12'h000) + {7'h00, s} + 12'h001;
  endfunction
  function automatic logic [ADDR_W-1:0] exp_rst(input logic f);
    return f ? 12'h000 : BOOT_RESET_ADDR;
  endfunction
  task automatic do_reset(input logic [CAUSE_N-1:0] c, input logic f);
    fuse = f;
    rsrc = c;
    @(negedge clk);
    rsrc = CAUSE_NONE;
    repeat (2) @(negedge clk);
    chk_flag("reset_fetch", 1'b1, fval & fisr);
    chk_addr("reset_addr", exp_rst(f), faddr);
    chk_cause("cause", c, cause);
    chk_flag("boot_active", ~f, boot);
    @(negedge clk);
  endtask
  task automatic do_take(input logic [SRC_W-1:0] s, input logic sel);
    vsel = sel;
    req = SRC_N'($random(seed));
    i_core.take(s, 1);
    if (s < 5'h19) chk_addr("vec_addr", exp_vec(sel, s), faddr);
    chk_flag("take_fetch", s < 5'h19, fval & ~fisr);
    chk_flag("bad_source", s > 5'h18, bad);
    if (s < 5'h19) chk_flag("spurious", ~req[s], spur);
    chk_flag("pending", |req, pend);
    chk_flag("vec_in_boot", sel, vinb);
    chk_flag("split", ~fuse ^ sel, split);
  endtask
  task automatic print_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // generous span: the whole run is well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    print_verdict;
  end
  initial begin
    rst = 1'b1;
    rsrc = CAUSE_NONE;
    fuse = 1'b1;
    vsel = 1'b0;
    req = '0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_flag("reset_fetch", 1'b1, fval & fisr);
    chk_addr("reset_addr", RESET_SLOT, faddr);
    chk_cause("cause", CAUSE_POWER_ON_ONLY, cause);
    @(negedge clk);
    $display("test power_up done");
    for (int i = 0; i < 8; i++)
      do_reset(4'h1 << i[1:0], i[2]);
    $display("test reset_causes done");
    for (int sel = 0; sel < 2; sel++)
      for (int s = 0; s < 32; s++)
        do_take(5'(s), sel[0]);
    $display("test vector_table done");
    vsel = 1'b1;
    i_core.take(5'h00, 25);
    $display("test burst done");
    for (int k = 0; k < 40; k++) begin
      rs = 5'($random(seed));
      if (k % 10 == 9)
        do_reset(4'($random(seed)) | 4'h1, rs[0]);
      else
        do_take(rs, rs[1]);
    end
    $display("test random done");
    // async reset mid-run must restart through strap and record power-on
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk_flag("reset_fetch", 1'b1, fval & fisr);
    chk_addr("reset_addr", exp_rst(fuse), faddr);
    chk_cause("cause", CAUSE_POWER_ON_ONLY, cause);
    @(negedge clk);
    $display("test async_reset done");
    print_verdict;
  end
endmodule // reset_irq_vector_placement_bench
bind rivp_top rivp_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reset_src(i_reset_src),
  .i_boot_reset_fuse(i_boot_reset_fuse), .i_vector_base_select(i_vector_base_select),
  .i_irq_req(i_irq_req), .i_irq_take(i_irq_take), .i_irq_source(i_irq_source),
  .o_take_ready(o_take_ready), .o_fetch_addr(o_fetch_addr), .o_fetch_valid(o_fetch_valid),
  .o_fetch_is_reset(o_fetch_is_reset), .o_reset_cause(o_reset_cause),
  .o_boot_reset_active(o_boot_reset_active), .o_vectors_in_boot(o_vectors_in_boot),
  .o_sections_split(o_sections_split), .o_spurious_take(o_spurious_take),
  .o_bad_source(o_bad_source));
